// ---- usbsr_consts.vh ----
`ifndef USBSR_CONSTS_VH
`define USBSR_CONSTS_VH

// --------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------
`define USBSR_OFS_GCTRL      8'hbc
`define USBSR_OFS_GINT       8'hbd
`define USBSR_OFS_GIEN       8'hbe
`define USBSR_OFS_EPIEN      8'hc2
`define USBSR_OFS_EPSEL      8'hc7
`define USBSR_OFS_EPSTAT     8'hce
`define USBSR_OFS_EPRST      8'hd5
`define USBSR_OFS_EPINT      8'hf8

// --------------------------------------------------------------------
// Global control fields
// --------------------------------------------------------------------
`define USBSR_GC_CE          7
`define USBSR_GC_SCG         6
`define USBSR_GC_SRW         5
`define USBSR_GC_URA         3
`define USBSR_GC_RWA         2
`define USBSR_GC_CFG         1
`define USBSR_GC_FAE         0

// --------------------------------------------------------------------
// Global flag and enable fields
// --------------------------------------------------------------------
`define USBSR_GI_WAKE        5
`define USBSR_GI_SUSP        0

// --------------------------------------------------------------------
// Endpoint status fields
// --------------------------------------------------------------------
`define USBSR_EP_IN          0
`define USBSR_EP_OB0         1
`define USBSR_EP_SETUP       2
`define USBSR_EP_STALL       3
`define USBSR_EP_OB1         6
`define USBSR_EP_TOG         7

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define USBSR_RST_GCTRL      8'h00
`define USBSR_RST_GIEN       8'h00
`define USBSR_RST_EPIEN      8'h00
`define USBSR_RST_EPSEL      8'h00

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define USBSR_CLK_MHZ        125
`define USBSR_SUSP_US        3000
`define USBSR_RWU_MIN_US     5000
`define USBSR_RSM_DRIVE_US   10000

`endif

// ---- usbsr_sync.v ----
`timescale 1ns/10ps
module usbsr_sync #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

// ---- usbsr_ep_flags.v ----
`timescale 1ns/10ps
`include "usbsr_consts.vh"
module usbsr_ep_flags #(
  parameter NUM_EP = 8,
  parameter IW     = 3
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              clr,
  input  wire [IW-1:0]     ev_ep,
  input  wire              ev_data0,
  input  wire              ev_data1,
  input  wire              ev_in,
  input  wire              ev_out0,
  input  wire              ev_out1,
  input  wire              ev_setup,
  input  wire              ev_stall,
  input  wire [IW-1:0]     sel,
  input  wire              st_wr,
  input  wire [7:0]        st_wdata,
  input  wire [NUM_EP-1:0] fifo_rst,
  output reg  [NUM_EP-1:0] in_q,
  output reg  [NUM_EP-1:0] ob0_q,
  output reg  [NUM_EP-1:0] ob1_q,
  output reg  [NUM_EP-1:0] setup_q,
  output reg  [NUM_EP-1:0] stall_q,
  output reg  [NUM_EP-1:0] tog_q
);
  reg [NUM_EP-1:0] in_d;
  reg [NUM_EP-1:0] ob0_d;
  reg [NUM_EP-1:0] ob1_d;
  reg [NUM_EP-1:0] setup_d;
  reg [NUM_EP-1:0] stall_d;
  reg [NUM_EP-1:0] tog_d;
  reg              hit;
  reg              wsel;
  integer          i;

  // Firmware clears a flag by writing 0; a hardware set in the same cycle wins
  always @* begin
    in_d    = in_q;
    ob0_d   = ob0_q;
    ob1_d   = ob1_q;
    setup_d = setup_q;
    stall_d = stall_q;
    tog_d   = tog_q;
    hit     = 1'b0;
    wsel    = 1'b0;
    for (i = 0; i < NUM_EP; i = i + 1) begin
      hit  = (ev_ep == i[IW-1:0]);
      wsel = st_wr && (sel == i[IW-1:0]);
      in_d[i]    = (hit & ev_in) |
                   (in_q[i] & ~(wsel & ~st_wdata[`USBSR_EP_IN]));
      ob0_d[i]   = (hit & ev_out0) |
                   (ob0_q[i] & ~(wsel & ~st_wdata[`USBSR_EP_OB0]));
      ob1_d[i]   = (hit & ev_out1) |
                   (ob1_q[i] & ~(wsel & ~st_wdata[`USBSR_EP_OB1]));
      setup_d[i] = (hit & ev_setup) |
                   (setup_q[i] & ~(wsel & ~st_wdata[`USBSR_EP_SETUP]));
      stall_d[i] = (hit & ev_stall) |
                   (stall_q[i] & ~(hit & ev_setup) &
                    ~(wsel & ~st_wdata[`USBSR_EP_STALL]));
      // A SETUP always carries DATA0, so it primes the bit like an accepted DATA0
      if (fifo_rst[i]) begin
        tog_d[i] = 1'b0;
      end else if (hit & (ev_data0 | ev_setup)) begin
        tog_d[i] = 1'b1;
      end else if (hit & ev_data1) begin
        tog_d[i] = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_q    <= {NUM_EP{1'b0}};
      ob0_q   <= {NUM_EP{1'b0}};
      ob1_q   <= {NUM_EP{1'b0}};
      setup_q <= {NUM_EP{1'b0}};
      stall_q <= {NUM_EP{1'b0}};
      tog_q   <= {NUM_EP{1'b0}};
    end else if (clr) begin
      in_q    <= {NUM_EP{1'b0}};
      ob0_q   <= {NUM_EP{1'b0}};
      ob1_q   <= {NUM_EP{1'b0}};
      setup_q <= {NUM_EP{1'b0}};
      stall_q <= {NUM_EP{1'b0}};
      tog_q   <= {NUM_EP{1'b0}};
    end else begin
      in_q    <= in_d;
      ob0_q   <= ob0_d;
      ob1_q   <= ob1_d;
      setup_q <= setup_d;
      stall_q <= stall_d;
      tog_q   <= tog_d;
    end
  end
endmodule

// ---- usbsr_top.v ----
// Functional notes
// - DATA0 accept sets toggle, DATA1 clears
// - Endpoint FIFO reset clears its toggle
// - SETUP starts DATA0; status stage uses DATA1
// - Suspend detected only when enabled, clocks running
// - Idle over 3 ms raises suspend flag
// - Clearing suspend flag while suspended idles transceiver pad, unless send-wakeup is set
// - Wake event brings pad out of idle
// - Resume detect while suspended sets wake flag
// - Send-wakeup request raises upstream-resume-active bit
// - Resume only if allowed, clocked, suspended 5 ms
// - Resume done clears active bit; firmware clears request
// - Host-accepted IN sets IN-complete flag
// - Stored OUT sets bank 0 or 1 flag
// - Accepted SETUP sets setup-received flag
// - STALL sent sets flag; SETUP clears it
// - Clearing enable resets controller, transceiver, clocks
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "usbsr_consts.vh"
module usbsr_top #(
  parameter NUM_EP   = 8,
  parameter IW       = 3,
  parameter SUSP_CYC = `USBSR_SUSP_US * `USBSR_CLK_MHZ,
  parameter RWU_CYC  = `USBSR_RWU_MIN_US * `USBSR_CLK_MHZ,
  parameter RSM_CYC  = `USBSR_RSM_DRIVE_US * `USBSR_CLK_MHZ
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire [7:0]        addr,
  input  wire [7:0]        wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [7:0]        rdata_q,
  input  wire              usb_dp_in,
  input  wire              usb_dm_in,
  input  wire              pll_ready,
  input  wire [IW-1:0]     ev_ep,
  input  wire              ev_data0,
  input  wire              ev_data1,
  input  wire              ev_in,
  input  wire              ev_out0,
  input  wire              ev_out1,
  input  wire              ev_setup,
  input  wire              ev_stall,
  output reg               usb_irq_q,
  output reg               xcvr_en_q,
  output reg               pad_idle_q,
  output reg               usb_clk_en_q,
  output reg               ctrl_rst_n_q,
  output reg               rsm_drive_k_q,
  output wire [NUM_EP-1:0] ep_toggle_q
);
  localparam CW = 21;
  localparam [CW-1:0] SUSP_LIM = SUSP_CYC[CW-1:0];
  localparam [CW-1:0] RWU_LIM  = RWU_CYC[CW-1:0];
  localparam [CW-1:0] RSM_LIM  = RSM_CYC[CW-1:0];
  localparam [7:0]    GCTRL_RST = `USBSR_RST_GCTRL;

  // --------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------
  wire [2:0] pins_s;
  wire       dp_s;
  wire       dm_s;
  wire       pll_s;

  usbsr_sync #(
    .W (3)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({pll_ready, usb_dm_in, usb_dp_in}),
    .q       (pins_s)
  );

  assign dp_s  = pins_s[0];
  assign dm_s  = pins_s[1];
  assign pll_s = pins_s[2];

  // Full-speed idle is the J state
  wire line_idle = dp_s & ~dm_s;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg              ce_q;
  reg              scg_q;
  reg              srw_q;
  reg              rwa_q;
  reg              cfg_q;
  reg              fae_q;
  reg              ura_q;
  reg              susp_flag_q;
  reg              wake_flag_q;
  reg              ien_susp_q;
  reg              ien_wake_q;
  reg [NUM_EP-1:0] epien_q;
  reg [IW-1:0]     epsel_q;
  reg [NUM_EP-1:0] eprst_q;
  reg              suspended_q;
  reg              rwu_done_q;
  reg [CW-1:0]     idle_cnt_q;
  reg [CW-1:0]     susp_cnt_q;
  reg [CW-1:0]     rsm_cnt_q;

  wire wr_gctrl  = wr && (addr == `USBSR_OFS_GCTRL);
  wire wr_gint   = wr && (addr == `USBSR_OFS_GINT);
  wire wr_gien   = wr && (addr == `USBSR_OFS_GIEN);
  wire wr_epien  = wr && (addr == `USBSR_OFS_EPIEN);
  wire wr_epsel  = wr && (addr == `USBSR_OFS_EPSEL);
  wire wr_epstat = wr && (addr == `USBSR_OFS_EPSTAT);
  wire wr_eprst  = wr && (addr == `USBSR_OFS_EPRST);

  // The USB clock runs only with the controller on, ungated, and the PLL up
  wire clk_run = ce_q & ~scg_q & pll_s;

  // --------------------------------------------------------------------
  // Endpoint flags and toggles
  // --------------------------------------------------------------------
  wire [NUM_EP-1:0] in_f;
  wire [NUM_EP-1:0] ob0_f;
  wire [NUM_EP-1:0] ob1_f;
  wire [NUM_EP-1:0] setup_f;
  wire [NUM_EP-1:0] stall_f;

  usbsr_ep_flags #(
    .NUM_EP (NUM_EP),
    .IW     (IW)
  ) u_ep (
    .clk      (clk),
    .reset_n  (reset_n),
    .clr      (~ce_q),
    .ev_ep    (ev_ep),
    .ev_data0 (ev_data0),
    .ev_data1 (ev_data1),
    .ev_in    (ev_in),
    .ev_out0  (ev_out0),
    .ev_out1  (ev_out1),
    .ev_setup (ev_setup),
    .ev_stall (ev_stall),
    .sel      (epsel_q),
    .st_wr    (wr_epstat),
    .st_wdata (wdata),
    .fifo_rst (eprst_q),
    .in_q     (in_f),
    .ob0_q    (ob0_f),
    .ob1_q    (ob1_f),
    .setup_q  (setup_f),
    .stall_q  (stall_f),
    .tog_q    (ep_toggle_q)
  );

  wire [NUM_EP-1:0] ep_any = in_f | ob0_f | ob1_f | setup_f | stall_f;

  // --------------------------------------------------------------------
  // Suspend, resume and remote wakeup
  // --------------------------------------------------------------------
  wire idle_hit  = clk_run & line_idle & ~suspended_q & (idle_cnt_q == SUSP_LIM);
  wire wake_ev   = suspended_q & ~line_idle & ~ura_q;
  wire susp_clr  = wr_gint & ~wdata[`USBSR_GI_SUSP] & susp_flag_q;
  wire rwu_start = srw_q & rwa_q & clk_run & suspended_q & ~ura_q &
                   ~rwu_done_q & (susp_cnt_q >= RWU_LIM);
  wire rsm_end   = ura_q & (rsm_cnt_q == RSM_LIM);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_q  <= {CW{1'b0}};
      susp_cnt_q  <= {CW{1'b0}};
      rsm_cnt_q   <= {CW{1'b0}};
      suspended_q <= 1'b0;
      susp_flag_q <= 1'b0;
      wake_flag_q <= 1'b0;
      pad_idle_q  <= 1'b0;
      ura_q       <= 1'b0;
      rwu_done_q  <= 1'b0;
    end else if (!ce_q) begin
      idle_cnt_q  <= {CW{1'b0}};
      susp_cnt_q  <= {CW{1'b0}};
      rsm_cnt_q   <= {CW{1'b0}};
      suspended_q <= 1'b0;
      susp_flag_q <= 1'b0;
      wake_flag_q <= 1'b0;
      pad_idle_q  <= 1'b0;
      ura_q       <= 1'b0;
      rwu_done_q  <= 1'b0;
    end else begin
      // Count up to the limit and hold there; the flag fires on the next idle cycle, so it needs more than the idle time
      if (!clk_run || !line_idle || suspended_q) begin
        idle_cnt_q <= {CW{1'b0}};
      end else if (idle_cnt_q != SUSP_LIM) begin
        idle_cnt_q <= idle_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
      if (idle_hit) begin
        suspended_q <= 1'b1;
      end else if (wake_ev || rsm_end) begin
        suspended_q <= 1'b0;
      end
      if (!suspended_q) begin
        susp_cnt_q <= {CW{1'b0}};
      end else if (susp_cnt_q != RWU_LIM) begin
        susp_cnt_q <= susp_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
      susp_flag_q <= idle_hit | (susp_flag_q & ~(wr_gint & ~wdata[`USBSR_GI_SUSP]));
      wake_flag_q <= wake_ev | (wake_flag_q & ~(wr_gint & ~wdata[`USBSR_GI_WAKE]));
      // Driving resume K needs a live pad, so an upstream resume wakes it too
      if (wake_ev || rwu_start) begin
        pad_idle_q <= 1'b0;
      end else if (susp_clr && suspended_q && !srw_q) begin
        pad_idle_q <= 1'b1;
      end
      if (rwu_start) begin
        ura_q     <= 1'b1;
        rsm_cnt_q <= {CW{1'b0}};
      end else if (rsm_end) begin
        ura_q <= 1'b0;
      end else if (ura_q) begin
        rsm_cnt_q <= rsm_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
      // One resume per request; firmware must drop the request to arm another
      if (rwu_start) begin
        rwu_done_q <= 1'b1;
      end else if (!srw_q) begin
        rwu_done_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_q       <= GCTRL_RST[`USBSR_GC_CE];
      scg_q      <= GCTRL_RST[`USBSR_GC_SCG];
      srw_q      <= GCTRL_RST[`USBSR_GC_SRW];
      rwa_q      <= GCTRL_RST[`USBSR_GC_RWA];
      cfg_q      <= GCTRL_RST[`USBSR_GC_CFG];
      fae_q      <= GCTRL_RST[`USBSR_GC_FAE];
      ien_susp_q <= 1'b0;
      ien_wake_q <= 1'b0;
      epien_q    <= {NUM_EP{1'b0}};
      epsel_q    <= {IW{1'b0}};
      eprst_q    <= {NUM_EP{1'b0}};
    end else begin
      if (wr_gctrl) begin
        ce_q  <= wdata[`USBSR_GC_CE];
        scg_q <= wdata[`USBSR_GC_SCG];
        srw_q <= wdata[`USBSR_GC_SRW];
        rwa_q <= wdata[`USBSR_GC_RWA];
        cfg_q <= wdata[`USBSR_GC_CFG];
        fae_q <= wdata[`USBSR_GC_FAE];
      end
      if (wr_gien) begin
        ien_susp_q <= wdata[`USBSR_GI_SUSP];
        ien_wake_q <= wdata[`USBSR_GI_WAKE];
      end
      if (wr_epien) begin
        epien_q <= wdata[NUM_EP-1:0];
      end
      if (wr_epsel) begin
        epsel_q <= wdata[IW-1:0];
      end
      // Endpoint reset bits act for one cycle and read back as zero
      eprst_q <= wr_eprst ? wdata[NUM_EP-1:0] : {NUM_EP{1'b0}};
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  function [7:0] ep_stat;
    input [IW-1:0]     s;
    input [NUM_EP-1:0] fi;
    input [NUM_EP-1:0] f0;
    input [NUM_EP-1:0] f1;
    input [NUM_EP-1:0] fs;
    input [NUM_EP-1:0] fk;
    input [NUM_EP-1:0] ft;
    begin
      ep_stat = 8'h00;
      ep_stat[`USBSR_EP_IN]    = fi[s];
      ep_stat[`USBSR_EP_OB0]   = f0[s];
      ep_stat[`USBSR_EP_OB1]   = f1[s];
      ep_stat[`USBSR_EP_SETUP] = fs[s];
      ep_stat[`USBSR_EP_STALL] = fk[s];
      ep_stat[`USBSR_EP_TOG]   = ft[s];
    end
  endfunction

  reg [7:0] rd_d;

  always @* begin
    rd_d = 8'h00;
    case (addr)
      `USBSR_OFS_GCTRL: begin
        rd_d[`USBSR_GC_CE]  = ce_q;
        rd_d[`USBSR_GC_SCG] = scg_q;
        rd_d[`USBSR_GC_SRW] = srw_q;
        rd_d[`USBSR_GC_URA] = ura_q;
        rd_d[`USBSR_GC_RWA] = rwa_q;
        rd_d[`USBSR_GC_CFG] = cfg_q;
        rd_d[`USBSR_GC_FAE] = fae_q;
      end
      `USBSR_OFS_GINT: begin
        rd_d[`USBSR_GI_SUSP] = susp_flag_q;
        rd_d[`USBSR_GI_WAKE] = wake_flag_q;
      end
      `USBSR_OFS_GIEN: begin
        rd_d[`USBSR_GI_SUSP] = ien_susp_q;
        rd_d[`USBSR_GI_WAKE] = ien_wake_q;
      end
      `USBSR_OFS_EPIEN: begin
        rd_d[NUM_EP-1:0] = epien_q;
      end
      `USBSR_OFS_EPSEL: begin
        rd_d[IW-1:0] = epsel_q;
      end
      `USBSR_OFS_EPSTAT: begin
        rd_d = ep_stat(epsel_q, in_f, ob0_f, ob1_f, setup_f, stall_f, ep_toggle_q);
      end
      `USBSR_OFS_EPINT: begin
        rd_d[NUM_EP-1:0] = ep_any;
      end
      default: begin
        rd_d = 8'h00;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q       <= 8'h00;
      usb_irq_q     <= 1'b0;
      xcvr_en_q     <= 1'b0;
      usb_clk_en_q  <= 1'b0;
      ctrl_rst_n_q  <= 1'b0;
      rsm_drive_k_q <= 1'b0;
    end else begin
      rdata_q       <= rd ? rd_d : 8'h00;
      usb_irq_q     <= (susp_flag_q & ien_susp_q) | (wake_flag_q & ien_wake_q) |
                       (|(ep_any & epien_q));
      xcvr_en_q     <= ce_q;
      usb_clk_en_q  <= clk_run;
      ctrl_rst_n_q  <= ce_q;
      rsm_drive_k_q <= ura_q & ~rsm_end;
    end
  end
endmodule

// ---- usbsr_properties.sv ----
`timescale 1ns/10ps
`include "usbsr_consts.vh"
module usbsr_properties #(
  parameter NUM_EP  = 8,
  parameter IW      = 3,
  parameter RSM_CYC = 10
) (
  input wire              clk,
  input wire              reset_n,
  input wire [7:0]        addr,
  input wire [7:0]        wdata,
  input wire              wr,
  input wire              usb_dp_in,
  input wire [IW-1:0]     ev_ep,
  input wire              ev_data0,
  input wire              ev_data1,
  input wire              ev_setup,
  input wire              usb_irq_q,
  input wire              xcvr_en_q,
  input wire              pad_idle_q,
  input wire              usb_clk_en_q,
  input wire              ctrl_rst_n_q,
  input wire              rsm_drive_k_q,
  input wire [NUM_EP-1:0] ep_toggle_q
);
  // ------------------------------------------------------------
  // Resume drive length
  // ------------------------------------------------------------
  reg [31:0] k_len_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      k_len_q <= 32'h0;
    end else if (rsm_drive_k_q) begin
      k_len_q <= k_len_q + 32'h1;
    end else begin
      k_len_q <= 32'h0;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A control write not overtaken by another one next cycle
  sequence s_ctl_wr;
    wr && addr == `USBSR_OFS_GCTRL ##1 !(wr && addr == `USBSR_OFS_GCTRL);
  endsequence
  sequence s_k_start;
    $rose(rsm_drive_k_q);
  endsequence
  property p_enable_out;
    s_ctl_wr |=> xcvr_en_q == $past(wdata[7], 2) && ctrl_rst_n_q == $past(wdata[7], 2);
  endproperty
  property p_off_quiet;
    !xcvr_en_q |-> !usb_clk_en_q && !pad_idle_q;
  endproperty
  property p_tog_set;
    ev_data0 && !ev_data1 && xcvr_en_q && !wr && !$past(wr) |=> ep_toggle_q[$past(ev_ep)];
  endproperty
  property p_tog_clr;
    ev_data1 && !ev_data0 && !ev_setup && xcvr_en_q && !wr && !$past(wr)
      |=> !ep_toggle_q[$past(ev_ep)];
  endproperty
  property p_fifo_rst;
    wr && addr == `USBSR_OFS_EPRST
      |-> ##2 (ep_toggle_q & $past(wdata[NUM_EP-1:0], 2)) == {NUM_EP{1'b0}};
  endproperty
  property p_wake_pad;
    pad_idle_q && xcvr_en_q && $fell(usb_dp_in) |-> ##[1:4] !pad_idle_q;
  endproperty
  property p_irq_hold;
    $fell(usb_irq_q) |-> $past(wr, 2) || $past(wr, 3);
  endproperty
  property p_rsm_len;
    $fell(rsm_drive_k_q) |-> k_len_q == RSM_CYC;
  endproperty
  property p_rsm_start;
    s_k_start |-> $past(usb_clk_en_q) && xcvr_en_q;
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("enable outputs wrong");
  a_off_quiet: assert property (p_off_quiet) else $error("disabled but active");
  a_tog_set: assert property (p_tog_set) else $error("toggle not set");
  a_tog_clr: assert property (p_tog_clr) else $error("toggle not cleared");
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo reset kept toggle");
  a_wake_pad: assert property (p_wake_pad) else $error("pad stayed idle");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  a_rsm_len: assert property (p_rsm_len) else $error("resume length wrong");
  a_rsm_start: assert property (p_rsm_start) else $error("resume without clock");
endmodule
bind usbsr_top usbsr_properties #(.NUM_EP(NUM_EP), .IW(IW), .RSM_CYC(RSM_CYC)) i_props (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .usb_dp_in(usb_dp_in),
  .ev_ep(ev_ep), .ev_data0(ev_data0), .ev_data1(ev_data1), .ev_setup(ev_setup),
  .usb_irq_q(usb_irq_q), .xcvr_en_q(xcvr_en_q), .pad_idle_q(pad_idle_q),
  .usb_clk_en_q(usb_clk_en_q), .ctrl_rst_n_q(ctrl_rst_n_q), .rsm_drive_k_q(rsm_drive_k_q),
  .ep_toggle_q(ep_toggle_q));

// ---- usbsr_host_model.sv ----
`timescale 1ns/10ps
module usbsr_host_model (
  input  wire       clk,
  input  wire [1:0] mode,
  output reg        usb_dp = 1'b1,
  output reg        usb_dm = 1'b0
);
  // Mode 0 traffic, 1 idle J, 2 resume K; traffic flips each cycle so idle never builds up
  reg flip_q = 1'b0;
  always @(posedge clk) begin
    flip_q <= ~flip_q;
    case (mode)
      2'h1: begin
        usb_dp <= 1'b1;
        usb_dm <= 1'b0;
      end
      2'h2: begin
        usb_dp <= 1'b0;
        usb_dm <= 1'b1;
      end
      default: begin
        usb_dp <= flip_q;
        usb_dm <= ~flip_q;
      end
    endcase
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "usbsr_consts.vh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  reg        clk       = 1'b0;
  reg        reset_n   = 1'b0;
  reg  [7:0] addr      = 8'h00;
  reg  [7:0] wdata     = 8'h00;
  reg        wr        = 1'b0;
  reg        rd        = 1'b0;
  reg        pll_ready = 1'b1;
  reg  [2:0] ev_ep     = 3'h0;
  reg  [6:0] ev        = 7'h00; // data0 data1 in out0 out1 setup stall
  reg  [1:0] host_mode = 2'h0;
  reg  [7:0] rv;
  wire [7:0] rdata_q;
  wire [7:0] tog;
  wire       dp, dm, irq, xcvr, pad, clken, crst, rsmk;
  int        fail_count  = 0;
  int        comparisons = 0;
  always #4 clk = ~clk;
  usbsr_top #(.SUSP_CYC(20), .RWU_CYC(30), .RSM_CYC(10)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .usb_dp_in(dp), .usb_dm_in(dm), .pll_ready(pll_ready), .ev_ep(ev_ep),
    .ev_data0(ev[0]), .ev_data1(ev[1]), .ev_in(ev[2]), .ev_out0(ev[3]), .ev_out1(ev[4]),
    .ev_setup(ev[5]), .ev_stall(ev[6]), .usb_irq_q(irq), .xcvr_en_q(xcvr), .pad_idle_q(pad),
    .usb_clk_en_q(clken), .ctrl_rst_n_q(crst), .rsm_drive_k_q(rsmk), .ep_toggle_q(tog));
  usbsr_host_model i_host (.clk(clk), .mode(host_mode), .usb_dp(dp), .usb_dm(dm));
  // ------------------------------------------------------------
  // Bus and event tasks
  // ------------------------------------------------------------
  task automatic bus_wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input [7:0] a, output [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic chk_rd(input [7:0] a, input [7:0] exp, input string nm);
    reg [7:0] d;
    bus_rd(a, d);
    `CHK(nm, exp, d)
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    ev_ep <= 3'h3;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    chk_rd(`USBSR_OFS_GCTRL, `USBSR_RST_GCTRL, "control reset");
    bus_wr(8'h10, 8'hff);
    chk_rd(8'h10, 8'h00, "unmapped");
    bus_wr(`USBSR_OFS_GCTRL, 8'h80);
    chk_rd(`USBSR_OFS_GCTRL, 8'h80, "control");
    `CHK("xcvr on", 1'b1, xcvr)
    `CHK("ctrl out of reset", 1'b1, crst)
  endtask
  task automatic t_toggle;
    bus_wr(`USBSR_OFS_EPSEL, 8'h03);
    pulse(0);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("toggle data0", 1'b1, rv[7])
    pulse(1);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("toggle data1", 1'b0, tog[3])
    pulse(0);
    bus_wr(`USBSR_OFS_EPRST, 8'h08);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("toggle fifo reset", 1'b0, rv[7])
    pulse(5);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("toggle setup", 1'b1, rv[7])
    `CHK("setup flag", 1'b1, rv[2])
  endtask
  task automatic t_flags;
    bus_wr(`USBSR_OFS_EPSTAT, 8'h00);
    bus_wr(`USBSR_OFS_EPIEN, 8'h08);
    pulse(6);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("stall flag", 1'b1, rv[3])
    `CHK("ep irq", 1'b1, irq)
    pulse(2);
    pulse(3);
    pulse(4);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("in out flags", 8'h4b, rv & 8'h4b)
    pulse(5);
    bus_rd(`USBSR_OFS_EPSTAT, rv);
    `CHK("stall cleared by setup", 1'b0, rv[3])
    chk_rd(`USBSR_OFS_EPINT, 8'h08, "ep any flag");
    bus_wr(`USBSR_OFS_EPSTAT, 8'h00);
    idle(3);
    `CHK("ep irq cleared", 1'b0, irq)
  endtask
  task automatic t_suspend;
    bus_wr(`USBSR_OFS_GIEN, 8'h21);
    bus_wr(`USBSR_OFS_GCTRL, 8'hc0);
    host_mode <= 2'h1;
    idle(40);
    chk_rd(`USBSR_OFS_GINT, 8'h00, "no suspend gated");
    bus_wr(`USBSR_OFS_GCTRL, 8'h80);
    idle(30);
    chk_rd(`USBSR_OFS_GINT, 8'h01, "suspend flag");
    `CHK("suspend irq", 1'b1, irq)
    bus_wr(`USBSR_OFS_GINT, 8'hfe);
    bus_wr(`USBSR_OFS_GCTRL, 8'hc0);
    pll_ready <= 1'b0;
    idle(2);
    `CHK("pad idle", 1'b1, pad)
    host_mode <= 2'h2;
    idle(8);
    `CHK("pad awake", 1'b0, pad)
    chk_rd(`USBSR_OFS_GINT, 8'h20, "wake flag");
    @(posedge clk);
    pll_ready <= 1'b1;
    host_mode <= 2'h0;
    bus_wr(`USBSR_OFS_GCTRL, 8'h80);
    bus_wr(`USBSR_OFS_GINT, 8'hdf);
  endtask
  task automatic t_remote;
    int n;
    host_mode <= 2'h1;
    bus_wr(`USBSR_OFS_GCTRL, 8'h84);
    idle(30);
    chk_rd(`USBSR_OFS_GINT, 8'h01, "second suspend");
    bus_wr(`USBSR_OFS_GINT, 8'hfe);
    bus_wr(`USBSR_OFS_GCTRL, 8'ha4);
    `CHK("no early resume", 1'b0, rsmk)
    for (n = 0; n < 100 && rsmk !== 1'b1; n++) idle(1);
    `CHK("resume drive", 1'b1, rsmk)
    `CHK("pad awake for resume", 1'b0, pad)
    bus_rd(`USBSR_OFS_GCTRL, rv);
    `CHK("resume active", 1'b1, rv[3])
    for (n = 0; n < 40 && rsmk !== 1'b0; n++) idle(1);
    bus_rd(`USBSR_OFS_GCTRL, rv);
    `CHK("resume done", 1'b0, rv[3])
    bus_wr(`USBSR_OFS_GCTRL, 8'h84);
  endtask
  task automatic t_disable;
    pulse(0);
    bus_wr(`USBSR_OFS_GCTRL, 8'h00);
    idle(2);
    `CHK("outputs off", 4'h0, {xcvr, crst, clken, pad})
    `CHK("toggles reset", 8'h00, tog)
    pulse(2);
    host_mode <= 2'h0;
    bus_wr(`USBSR_OFS_GCTRL, 8'h80);
    bus_wr(`USBSR_OFS_EPSEL, 8'h03);
    chk_rd(`USBSR_OFS_EPSTAT, 8'h00, "flags after disable");
  endtask
  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task report_and_stop;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_toggle;
    t_flags;
    t_suspend;
    t_remote;
    t_disable;
    report_and_stop;
  end
endmodule
